// ---- rtl/assc_top.v ----
// Operation
// - set rx full on load, even with faults
// - rx full clears: read, carrier, halt, reset
// - overrun when holding and fifo full and another char completes
// - error flags clear: clear bit zero, carrier, halt
// - parity fault only with parity enabled
// - framing fault when stop bit is zero
// - rx irq from flags when enabled
// - carrier rising edge also raises rx irq
// - shared pin: cts or clocked rx, by select
// - tx empty clears on write, sets on move
// - tx empty: one in halt, zero on cts
// - tx irq when enabled and empty
// - wakeup filter keeps only address bytes
// - filter inert without multidrop or when off
// - shared bit reads address flag, zero clears
// - format bits: length, parity, stop count
// - rx disable aborts, keeps flags
// - tx disable aborts, keeps tx empty
`timescale 1ns/10ps
`default_nettype none
`include "assc_regs.vh"

module assc_fifo #(
   parameter WIDTH = 11,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_flush,
   input wire i_valid,
   output wire o_ready,
   input wire [WIDTH-1:0] i_data,
   output wire o_valid,
   input wire i_ready,
   output wire [WIDTH-1:0] o_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   wire push = i_valid & o_ready;
   wire pop = o_valid & i_ready;
   assign o_ready = (count_ff != DEPTH[AW:0]);
   assign o_valid = (count_ff != {(AW+1){1'b0}});
   assign o_data = mem[rd_ptr_ff];
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= i_data;
      end
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // assc_fifo

module assc_top #(
   parameter BIT_CYCLES = `ASSC_BIT_CYCLES,
   parameter PARITY_ODD = 0,
   parameter FIFO_DEPTH = 8
) (
   input wire i_core_clk,
   input wire i_rst_n,
   input wire [7:0] i_io_addr,
   input wire i_io_wr,
   input wire i_io_rd,
   input wire [7:0] i_io_wdata,
   output reg [7:0] o_io_rdata,
   input wire i_rxd,
   output reg o_txd,
   input wire i_carrier_detect_in,
   input wire i_ch1_shared_pin,
   output reg o_clocked_serial_rx_in,
   input wire i_io_halt_mode,
   input wire i_multidrop_format,
   input wire i_tx_addr_flag,
   output reg o_request_send_out0,
   output reg o_rx_irq,
   output reg o_tx_irq
);
   localparam R_IDLE = 2'h0;
   localparam R_START = 2'h1;
   localparam R_BITS = 2'h2;
   localparam [15:0] BIT_M1 = BIT_CYCLES - 1;
   localparam [15:0] HALF = BIT_CYCLES / 2;
   localparam PAR_ODD_B = (PARITY_ODD != 0);

   reg [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // pins: three stages, a change counts when stages two and three agree
   reg [2:0] pin_s1_ff;
   reg [2:0] pin_s2_ff;
   reg [2:0] pin_s3_ff;
   reg [2:0] pin_ff;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle levels: rxd high, carrier and shared pin low, so no false edge
         pin_s1_ff <= 3'h1;
         pin_s2_ff <= 3'h1;
         pin_s3_ff <= 3'h1;
         pin_ff <= 3'h1;
      end else begin
         pin_s1_ff <= {i_ch1_shared_pin, i_carrier_detect_in, i_rxd};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_ff <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
      end
   end
   wire rxd = pin_ff[0];
   wire dcd = pin_ff[1];
   wire shared = pin_ff[2];

   reg [7:0] ctrl_ff;
   reg rx_full_flag_ff, overrun_flag_ff, parity_fault_flag_ff, stop_bit_fault_flag_ff;
   reg rx_irq_on_ff, ch1_pin_select_ff, tx_empty_flag_ff, tx_irq_on_ff;
   reg dcd_d_ff, dcd_evt_ff, last_addr_bit_ff;
   reg [7:0] rx_holding_reg_ff, tx_holding_reg_ff;

   wire halt = i_io_halt_mode;
   wire mdrop = i_multidrop_format;
   wire len8 = ctrl_ff[`ASSC_CA_LEN];
   wire par_on = ctrl_ff[`ASSC_CA_PAR];
   wire rx_on = ctrl_ff[`ASSC_CA_RX_ON];
   wire tx_on = ctrl_ff[`ASSC_CA_TX_ON];
   wire wr_ctrl = i_io_wr & (i_io_addr == `ASSC_ADDR_CTRL_A);
   wire wr_stat = i_io_wr & (i_io_addr == `ASSC_ADDR_STATUS);
   wire wr_tx = i_io_wr & (i_io_addr == `ASSC_ADDR_TX_HOLD);
   wire rd_rx = i_io_rd & (i_io_addr == `ASSC_ADDR_RX_HOLD);
   wire rd_stat = i_io_rd & (i_io_addr == `ASSC_ADDR_STATUS);
   wire err_clr = wr_ctrl & ~i_io_wdata[`ASSC_CA_ADDR_ERR_CLR];
   wire cts_hi = ch1_pin_select_ff & shared;
   wire tx_flag = tx_empty_flag_ff & ~cts_hi;

   // receive shifter
   reg [1:0] rx_st_ff;
   reg [15:0] rx_cnt_ff;
   reg [3:0] rx_idx_ff;
   reg [11:0] rx_bits_ff;
   wire [3:0] dlen = 4'h7 + {3'h0, len8};
   wire [3:0] rx_last = dlen + {3'h0, par_on} + {3'h0, mdrop};
   wire rx_done = (rx_st_ff == R_BITS) & (rx_cnt_ff == 16'h0000) & (rx_idx_ff == rx_last);
   wire [7:0] rx_data = len8 ? rx_bits_ff[7:0] : {1'b0, rx_bits_ff[6:0]};
   wire rx_par_bit = rx_bits_ff[dlen];
   wire rx_addr_bit = rx_bits_ff[dlen + {3'h0, par_on}];
   wire rx_par_err = par_on & (^rx_data ^ rx_par_bit ^ PAR_ODD_B);
   wire rx_stop_err = ~rxd;
   wire rx_keep = ~(mdrop & ctrl_ff[`ASSC_CA_WAKEUP] & ~rx_addr_bit);
   wire rx_abort = ~rx_on | dcd | halt;

   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_ff <= R_IDLE;
         rx_cnt_ff <= 16'h0000;
         rx_idx_ff <= 4'h0;
         rx_bits_ff <= 12'h000;
      end else if (rx_abort) begin
         rx_st_ff <= R_IDLE;
      end else begin
         case (rx_st_ff)
            R_IDLE: begin
               if (!rxd) begin
                  rx_st_ff <= R_START;
                  // confirm the start bit near its middle, not at its end
                  rx_cnt_ff <= HALF - 16'h0001;
               end
            end
            R_START: begin
               if (rx_cnt_ff != 16'h0000) begin
                  rx_cnt_ff <= rx_cnt_ff - 16'h0001;
               end else if (!rxd) begin
                  rx_st_ff <= R_BITS;
                  rx_cnt_ff <= BIT_M1;
                  rx_idx_ff <= 4'h0;
               end else begin
                  rx_st_ff <= R_IDLE;
               end
            end
            R_BITS: begin
               if (rx_cnt_ff != 16'h0000) begin
                  rx_cnt_ff <= rx_cnt_ff - 16'h0001;
               end else begin
                  rx_bits_ff[rx_idx_ff] <= rxd;
                  rx_cnt_ff <= BIT_M1;
                  rx_idx_ff <= rx_idx_ff + 4'h1;
                  if (rx_idx_ff == rx_last) begin
                     rx_st_ff <= R_IDLE;
                  end
               end
            end
            default: begin
               rx_st_ff <= R_IDLE;
            end
         endcase
      end
   end

   // received characters wait in the fifo until the holding register is free
   wire fifo_in_ready, fifo_out_valid;
   wire [9:0] fifo_out;
   wire rx_push = rx_done & rx_keep & ~rx_abort;
   wire rx_clr = dcd | halt;
   wire rx_load = fifo_out_valid & ~rx_full_flag_ff & ~rx_clr;
   assc_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH), .AW(3)) u_rx_fifo (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_flush(rx_clr),
      .i_valid(rx_push),
      .o_ready(fifo_in_ready),
      .i_data({rx_stop_err, rx_par_err, rx_data}),
      .o_valid(fifo_out_valid),
      .i_ready(~rx_full_flag_ff & ~rx_clr),
      .o_data(fifo_out)
   );
   wire ovr_set = rx_push & ~fifo_in_ready;

   // transmit shifter
   reg [12:0] tx_sh_ff;
   reg [3:0] tx_left_ff;
   reg [15:0] tx_cnt_ff;
   reg [12:0] tx_frame;
   reg [3:0] tx_pos;
   wire [7:0] tx_data = len8 ? tx_holding_reg_ff : {1'b0, tx_holding_reg_ff[6:0]};
   wire tx_busy = (tx_left_ff != 4'h0);
   wire tx_move = ~tx_busy & tx_on & ~tx_empty_flag_ff & ~cts_hi & ~halt;
   wire [3:0] tx_len = dlen + {3'h0, par_on} + {3'h0, mdrop} + {3'h0, ctrl_ff[`ASSC_CA_STOP]}
                       + 4'h2;
   always @* begin
      tx_frame = 13'h1FFF;
      tx_frame[0] = 1'b0;
      tx_frame[7:1] = tx_data[6:0];
      if (len8) begin
         tx_frame[8] = tx_data[7];
      end
      tx_pos = dlen + 4'h1;
      if (par_on) begin
         tx_frame[tx_pos] = ^tx_data ^ PAR_ODD_B;
         tx_pos = tx_pos + 4'h1;
      end
      if (mdrop) begin
         tx_frame[tx_pos] = i_tx_addr_flag;
      end
   end
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_ff <= 13'h1FFF;
         tx_left_ff <= 4'h0;
         tx_cnt_ff <= 16'h0000;
         o_txd <= 1'b1;
      end else begin
         o_txd <= ~tx_busy | tx_sh_ff[0];
         if (~tx_on | halt) begin
            tx_left_ff <= 4'h0;
         end else if (tx_move) begin
            tx_sh_ff <= tx_frame;
            tx_left_ff <= tx_len;
            tx_cnt_ff <= BIT_M1;
         end else if (tx_busy) begin
            if (tx_cnt_ff != 16'h0000) begin
               tx_cnt_ff <= tx_cnt_ff - 16'h0001;
            end else begin
               tx_sh_ff <= {1'b1, tx_sh_ff[12:1]};
               tx_left_ff <= tx_left_ff - 4'h1;
               tx_cnt_ff <= BIT_M1;
            end
         end
      end
   end

   // registers and flags
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `ASSC_RST_CTRL_A;
         rx_full_flag_ff <= 1'b0;
         overrun_flag_ff <= 1'b0;
         parity_fault_flag_ff <= 1'b0;
         stop_bit_fault_flag_ff <= 1'b0;
         rx_irq_on_ff <= 1'b0;
         ch1_pin_select_ff <= 1'b0;
         tx_empty_flag_ff <= 1'b1;
         tx_irq_on_ff <= 1'b0;
         dcd_d_ff <= 1'b0;
         dcd_evt_ff <= 1'b0;
         last_addr_bit_ff <= 1'b0;
         rx_holding_reg_ff <= 8'h00;
         tx_holding_reg_ff <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= i_io_wdata;
         end
         if (halt) begin
            ctrl_ff[`ASSC_CA_RX_ON] <= 1'b0;
            ctrl_ff[`ASSC_CA_TX_ON] <= 1'b0;
         end
         if (wr_stat) begin
            rx_irq_on_ff <= i_io_wdata[`ASSC_ST_RX_IRQ_ON];
            ch1_pin_select_ff <= i_io_wdata[`ASSC_ST_PIN_SEL];
            tx_irq_on_ff <= i_io_wdata[`ASSC_ST_TX_IRQ_ON];
         end
         if (rx_done & mdrop) begin
            last_addr_bit_ff <= rx_addr_bit;
         end
         if (rx_load) begin
            rx_holding_reg_ff <= fifo_out[7:0];
         end
         rx_full_flag_ff <= ~rx_clr & (rx_load | (rx_full_flag_ff & ~rd_rx));
         overrun_flag_ff <= ~rx_clr & (ovr_set | (overrun_flag_ff & ~err_clr));
         parity_fault_flag_ff <= ~rx_clr & ((rx_load & fifo_out[8])
                                 | (parity_fault_flag_ff & ~err_clr));
         stop_bit_fault_flag_ff <= ~rx_clr & ((rx_load & fifo_out[9])
                                   | (stop_bit_fault_flag_ff & ~err_clr));
         dcd_d_ff <= dcd;
         dcd_evt_ff <= (dcd & ~dcd_d_ff) | (dcd_evt_ff & ~rd_stat);
         if (wr_tx) begin
            tx_holding_reg_ff <= i_io_wdata;
         end
         if (halt) begin
            tx_empty_flag_ff <= 1'b1;
         end else if (wr_tx) begin
            tx_empty_flag_ff <= 1'b0;
         end else if (tx_move) begin
            tx_empty_flag_ff <= 1'b1;
         end
      end
   end

   // registered outputs
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_io_rdata <= 8'h00;
         o_clocked_serial_rx_in <= 1'b1;
         o_request_send_out0 <= 1'b1;
         o_rx_irq <= 1'b0;
         o_tx_irq <= 1'b0;
      end else begin
         if (i_io_rd) begin
            case (i_io_addr)
               `ASSC_ADDR_CTRL_A: o_io_rdata <= {ctrl_ff[7:4], last_addr_bit_ff, ctrl_ff[2:0]};
               `ASSC_ADDR_STATUS: o_io_rdata <= {rx_full_flag_ff, overrun_flag_ff,
                  parity_fault_flag_ff, stop_bit_fault_flag_ff, rx_irq_on_ff,
                  ch1_pin_select_ff, tx_flag, tx_irq_on_ff};
               `ASSC_ADDR_TX_HOLD: o_io_rdata <= tx_holding_reg_ff;
               `ASSC_ADDR_RX_HOLD: o_io_rdata <= rx_holding_reg_ff;
               default: o_io_rdata <= 8'h00;
            endcase
         end
         o_clocked_serial_rx_in <= ch1_pin_select_ff | shared;
         o_request_send_out0 <= ctrl_ff[`ASSC_CA_RTS];
         o_rx_irq <= rx_irq_on_ff & (rx_full_flag_ff | overrun_flag_ff | parity_fault_flag_ff
                     | stop_bit_fault_flag_ff | dcd_evt_ff);
         o_tx_irq <= tx_irq_on_ff & tx_flag;
      end
   end
endmodule // assc_top
`default_nettype wire

// ---- rtl/assc_regs.vh ----
`ifndef ASSC_REGS_VH
`define ASSC_REGS_VH

// register addresses on the i/o port
`define ASSC_ADDR_CTRL_A 8'h00
`define ASSC_ADDR_STATUS 8'h05
`define ASSC_ADDR_TX_HOLD 8'h06
`define ASSC_ADDR_RX_HOLD 8'h08

// control_a_reg field positions
`define ASSC_CA_WAKEUP 7
`define ASSC_CA_RX_ON 6
`define ASSC_CA_TX_ON 5
`define ASSC_CA_RTS 4
`define ASSC_CA_ADDR_ERR_CLR 3
`define ASSC_CA_LEN 2
`define ASSC_CA_PAR 1
`define ASSC_CA_STOP 0

// status field positions
`define ASSC_ST_RX_FULL 7
`define ASSC_ST_OVERRUN 6
`define ASSC_ST_PARITY 5
`define ASSC_ST_FRAMING 4
`define ASSC_ST_RX_IRQ_ON 3
`define ASSC_ST_PIN_SEL 2
`define ASSC_ST_TX_EMPTY 1
`define ASSC_ST_TX_IRQ_ON 0

// reset values
`define ASSC_RST_CTRL_A 8'h10
`define ASSC_RST_STATUS 8'h00

// default bit time in core clocks
`define ASSC_BIT_CYCLES 16

`endif

// ---- verification/assc_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module assc_top_sva #(parameter int BIT_CYCLES = 16) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic [7:0] o_io_rdata,
   input wire logic o_txd,
   input wire logic i_carrier_detect_in,
   input wire logic i_ch1_shared_pin,
   input wire logic o_clocked_serial_rx_in,
   input wire logic i_io_halt_mode,
   input wire logic o_request_send_out0,
   input wire logic o_rx_irq,
   input wire logic o_tx_irq
);
   logic [7:0] low_cnt_ff;
   logic rx_irq_en_ff;
   logic tx_irq_en_ff;
   wire logic st_rd = i_io_rd && i_io_addr == 8'h05;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_ff <= 8'h00;
         rx_irq_en_ff <= 1'b0;
         tx_irq_en_ff <= 1'b0;
      end else begin
         low_cnt_ff <= o_txd ? 8'h00 : low_cnt_ff + 8'h01;
         if (i_io_wr && i_io_addr == 8'h05) begin
            rx_irq_en_ff <= i_io_wdata[3];
            tx_irq_en_ff <= i_io_wdata[0];
         end
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   a_rts_follow_bit:
      assert property ((i_io_wr && i_io_addr == 8'h00) ##1 !i_io_wr
         |=> o_request_send_out0 == $past(i_io_wdata[4], 2)) else $error("rts pin off its bit");
   a_pin_route_rx:
      assert property (!o_clocked_serial_rx_in |-> !$past(i_ch1_shared_pin, 3)
         || !$past(i_ch1_shared_pin, 4) || !$past(i_ch1_shared_pin, 5)
         || !$past(i_ch1_shared_pin, 6)) else $error("shared pin route wrong");
   a_carrier_clears_flags:
      assert property (i_carrier_detect_in[*6] ##0 st_rd |=> o_io_rdata[7:4] == 4'h0)
         else $error("flags kept under carrier");
   a_halt_clears_flags:
      assert property (i_io_halt_mode[*3] ##0 st_rd |=> o_io_rdata[7:4] == 4'h0 && o_io_rdata[1])
         else $error("halt flags wrong");
   a_unmapped_read_zero:
      assert property (i_io_rd && !(i_io_addr inside {8'h00, 8'h05, 8'h06, 8'h08})
         |=> o_io_rdata == 8'h00) else $error("unmapped read not zero");
   a_txd_bit_time:
      assert property ($rose(o_txd) && !i_io_halt_mode |-> low_cnt_ff != 8'h00
         && low_cnt_ff % BIT_CYCLES == 0) else $error("tx low run not whole bits");
   a_rx_irq_gated:
      assert property (o_rx_irq |-> rx_irq_en_ff || $past(rx_irq_en_ff))
         else $error("rx irq while off");
   a_tx_irq_gated:
      assert property (o_tx_irq |-> tx_irq_en_ff || $past(tx_irq_en_ff))
         else $error("tx irq while off");
   a_txd_halt_idle:
      assert property (i_io_halt_mode[*4] |-> o_txd) else $error("tx line busy in halt");
endmodule // assc_top_sva
bind assc_top assc_top_sva #(.BIT_CYCLES(BIT_CYCLES)) i_sva (.i_core_clk, .i_rst_n,
   .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_txd, .i_carrier_detect_in,
   .i_ch1_shared_pin, .o_clocked_serial_rx_in, .i_io_halt_mode, .o_request_send_out0,
   .o_rx_irq, .o_tx_irq);
`default_nettype wire

// ---- verification/assc_remote_station.sv ----
`timescale 1ns/10ps
`default_nettype none
module assc_remote_station #(parameter int BIT_CYCLES = 4) (
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd
);
   logic [7:0] got;
   logic [2:0] tail;
   initial o_rxd = 1'b1;
   task automatic send(input logic [7:0] d, input logic len8, input logic par_on,
      input logic bad_par, input logic mdrop_on, input logic addr, input logic stop);
      logic q[$];
      q.push_back(1'b0);
      for (int i = 0; i < 7 + len8; i++) q.push_back(d[i]);
      if (par_on) q.push_back((len8 ? ^d : ^d[6:0]) ^ bad_par);
      if (mdrop_on) q.push_back(addr);
      q.push_back(stop);
      foreach (q[i]) begin
         o_rxd = q[i];
         repeat (BIT_CYCLES) @(negedge i_clk);
      end
      o_rxd = 1'b1;
   endtask
   // listens for 8 data bits, then keeps the next three bit times in tail
   initial begin
      forever begin
         @(negedge i_txd);
         repeat (BIT_CYCLES / 2) @(posedge i_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge i_clk);
            got[i] = i_txd;
         end
         for (int i = 0; i < 3; i++) begin
            repeat (BIT_CYCLES) @(posedge i_clk);
            tail[i] = i_txd;
         end
      end
   end
endmodule // assc_remote_station
`default_nettype wire

// ---- verification/assc_top_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module assc_top_test;
   localparam int BITC = 4;
   logic clk, rst_n, wr, rd, carrier, pin, halt, mdrop, addr_flag;
   logic [7:0] addr, wdata, rq;
   wire logic [7:0] rdata;
   wire logic rxd, txd, csrx, rts, rx_irq, tx_irq;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   assc_top #(.BIT_CYCLES(BITC)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_io_addr(addr),
      .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .i_rxd(rxd),
      .o_txd(txd), .i_carrier_detect_in(carrier), .i_ch1_shared_pin(pin),
      .o_clocked_serial_rx_in(csrx), .i_io_halt_mode(halt), .i_multidrop_format(mdrop),
      .i_tx_addr_flag(addr_flag), .o_request_send_out0(rts), .o_rx_irq(rx_irq),
      .o_tx_irq(tx_irq));
   assc_remote_station #(.BIT_CYCLES(BITC)) i_remote (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      rq = rdata;
   endtask
   task automatic t_reset();
      rd_reg(8'h05);
      `CHK(rq, 8'h02)
      rd_reg(8'h00);
      `CHK(rq, 8'h10)
      `CHK({rts, txd, rx_irq, tx_irq}, 4'hC)
      $display("reset test done");
   endtask
   task automatic t_rx_and_errors();
      wr_reg(8'h00, 8'h44);
      i_remote.send(8'hA5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      `CHK(rts, 1'b0)
      rd_reg(8'h05);
      `CHK(rq, 8'h82)
      rd_reg(8'h08);
      `CHK(rq, 8'hA5)
      wr_reg(8'h00, 8'h42);
      wr_reg(8'h05, 8'h08);
      i_remote.send(8'h55, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (10) @(negedge clk);
      `CHK(rx_irq, 1'b1)
      rd_reg(8'h05);
      `CHK(rq, 8'hBA)
      rd_reg(8'h08);
      `CHK(rq, 8'h55)
      wr_reg(8'h00, 8'h46);
      rd_reg(8'h05);
      `CHK(rq, 8'h0A)
      i_remote.send(8'h07, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h05);
      `CHK(rq, 8'h8A)
      rd_reg(8'h08);
      $display("receive test done");
   endtask
   task automatic t_overrun();
      wr_reg(8'h00, 8'h44);
      for (int i = 0; i < 10; i++) i_remote.send(8'(i), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h05);
      `CHK(rq, 8'hCA)
      for (int i = 0; i < 9; i++) begin
         rd_reg(8'h08);
         `CHK(rq, 8'(i))
      end
      wr_reg(8'h00, 8'h44);
      rd_reg(8'h05);
      `CHK(rq, 8'h0A)
      $display("overrun test done");
   endtask
   task automatic t_multidrop();
      mdrop = 1'b1;
      wr_reg(8'h00, 8'hC4);
      i_remote.send(8'h11, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h05);
      `CHK(rq[7], 1'b0)
      i_remote.send(8'h22, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h00);
      `CHK(rq, 8'hCC)
      rd_reg(8'h08);
      `CHK(rq, 8'h22)
      wr_reg(8'h00, 8'h44);
      i_remote.send(8'h33, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h08);
      `CHK(rq, 8'h33)
      mdrop = 1'b0;
      i_remote.send(8'h5A, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk);
      rd_reg(8'h08);
      `CHK(rq, 8'h5A)
      `CHK(rx_irq, 1'b0)
      carrier = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(rx_irq, 1'b1)
      rd_reg(8'h05);
      `CHK(rq[7:4], 4'h0)
      carrier = 1'b0;
      repeat (8) @(negedge clk);
      rd_reg(8'h05);
      repeat (3) @(negedge clk);
      `CHK(rx_irq, 1'b0)
      $display("multidrop and carrier test done");
   endtask
   task automatic t_tx_and_halt();
      wr_reg(8'h05, 8'hFF);
      rd_reg(8'h05);
      `CHK(rq, 8'h0F)
      `CHK({tx_irq, csrx}, 2'b11)
      wr_reg(8'h05, 8'h09);
      wr_reg(8'h06, 8'h77);
      rd_reg(8'h05);
      `CHK(rq, 8'h09)
      `CHK(tx_irq, 1'b0)
      mdrop = 1'b1;
      addr_flag = 1'b1;
      wr_reg(8'h00, 8'h67);
      repeat (70) @(negedge clk);
      `CHK(i_remote.got, 8'h77)
      `CHK(i_remote.tail, 3'b110)
      mdrop = 1'b0;
      wr_reg(8'h05, 8'h0D);
      pin = 1'b1;
      repeat (8) @(negedge clk);
      rd_reg(8'h05);
      `CHK(rq, 8'h0D)
      wr_reg(8'h05, 8'h09);
      pin = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(csrx, 1'b0)
      wr_reg(8'h06, 8'h81);
      repeat (6) @(negedge clk);
      halt = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(txd, 1'b1)
      rd_reg(8'h05);
      `CHK(rq[1], 1'b1)
      rd_reg(8'h00);
      `CHK(rq[6:5], 2'b00)
      halt = 1'b0;
      rd_reg(8'h03);
      $display("transmit and halt test done");
   endtask
   initial begin
      {rst_n, wr, rd, carrier, pin, halt, mdrop, addr_flag} = 8'h00;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_rx_and_errors();
      t_overrun();
      t_multidrop();
      t_tx_and_halt();
      report_and_stop();
   end
endmodule // assc_top_test
`default_nettype wire
